// ==== hw/bbfc_host.sv ====
// Host-side controller that drives the boot-block flash parallel bus
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Byte mode drives the top pin as lowest address bit.
// - Commands travel on the low eight data lines only.
// - Program supply held high from confirm or data cycle to completion.
// - Erase is setup 20H then confirm D0H, back to back.
// - Program is setup 40H then address and data cycle.
// - Read-array FFH is issued before array reads after program or erase; software sends it, the controller only flags the need in status.
// - Boot block needs reset pin at unlock level or write-protect high.
// - High-voltage identify: address nine high-voltage, other upper bits low.
// - Write-enable low cycle is a write.
module bbfc_host
	import bbfc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic             WB_ACK_O,
	input  wire logic        FL_BUSY,
	output var bbfc_pins_t   FL_PINS,
	input  wire logic [15:0] FL_DQ_I,
	output logic      [15:0] FL_DQ_O,
	output logic      [15:0] FL_DQ_OE
);
////////////////////////////////////////////////////////////////////////////////
	logic [8:0]  ctrl_q;
	logic [18:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic        done_q;
	logic        ack_q;
	bbfc_state_t st_q;
	logic [3:0]  cnt_q;
	logic        write_cyc_q;
	logic        hold_vpp_q;
	logic        need_rdarray_q;
	logic [7:0]  cmd1_q;
	logic [15:0] data2_q;
	logic        two_q;
	logic        wb_req;
	logic        go;
	logic [2:0]  op;
	logic        word;

	// Byte lane merge shared by all writable registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
	assign go     = wb_req & WB_WE_I & (WB_ADR_I == REG_CTRL) & WB_SEL_I[0]
	                & WB_DAT_I[CTRL_GO_BIT] & (st_q == ST_IDLE);
	assign op     = ctrl_q[CTRL_OP_LSB +: 3];
	assign word   = ctrl_q[CTRL_WORD_BIT];
	assign WB_ACK_O = ack_q;

	// Single-cycle ack; unmapped offsets answer zero and ignore writes
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ack_q    <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			ack_q <= wb_req;
			case (WB_ADR_I)
				REG_CTRL:   WB_DAT_O <= {23'h000000, ctrl_q};
				REG_ADDR:   WB_DAT_O <= {13'h0000, addr_q};
				REG_WDATA:  WB_DAT_O <= {rdata_q, wdata_q};
				REG_STATUS: WB_DAT_O <= {29'h00000000, need_rdarray_q, done_q, st_q != ST_IDLE};
				default:    WB_DAT_O <= 32'h00000000;
			endcase
		end
	end

	// Software registers; go bit self-clears and is never stored
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q  <= 9'h100;
			addr_q  <= 19'h00000;
			wdata_q <= 16'h0000;
		end else if (wb_req & WB_WE_I) begin
			case (WB_ADR_I)
				REG_CTRL:  ctrl_q  <= 9'(merge({23'h000000, ctrl_q},
				                               WB_DAT_I, WB_SEL_I) & 32'h000001FE);
				REG_ADDR:  addr_q  <= 19'(merge({13'h0000, addr_q}, WB_DAT_I, WB_SEL_I));
				REG_WDATA: wdata_q <= 16'(merge({16'h0000, wdata_q}, WB_DAT_I, WB_SEL_I));
				default: ;
			endcase
		end
	end

	// Bus cycle sequencer: one or two strobed cycles per operation
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q        <= ST_IDLE;
			cnt_q       <= 4'h0;
			write_cyc_q <= 1'b0;
			two_q       <= 1'b0;
			cmd1_q      <= 8'h00;
			data2_q     <= 16'h0000;
			done_q      <= 1'b0;
			rdata_q     <= 16'h0000;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (go) begin
						done_q <= 1'b0;
						cnt_q  <= STROBE_CYC;
						st_q   <= ST_SETUP;
						case (WB_DAT_I[CTRL_OP_LSB +: 3])
							OP_PROGRAM: begin
								write_cyc_q <= 1'b1;
								two_q       <= 1'b1;
								cmd1_q      <= CMD_PROG_SETUP;
								data2_q     <= wdata_q;
							end
							OP_ERASE: begin
								write_cyc_q <= 1'b1;
								two_q       <= 1'b1;
								cmd1_q      <= CMD_ERASE_SETUP;
								data2_q     <= {8'h00, CMD_ERASE_CONF};
							end
							OP_RDARRAY: begin
								write_cyc_q <= 1'b1;
								two_q       <= 1'b0;
								cmd1_q      <= CMD_READ_ARRAY;
							end
							OP_IDCMD: begin
								write_cyc_q <= 1'b1;
								two_q       <= 1'b0;
								cmd1_q      <= CMD_IDENTIFY;
							end
							default: begin
								write_cyc_q <= 1'b0;
								two_q       <= 1'b0;
							end
						endcase
					end
				end
				ST_SETUP, ST_CYC2: begin
					if (cnt_q > 4'h1) begin
						cnt_q <= cnt_q - 4'h1;
					end else begin
						// Read data sampled at the end of the output enable window
						if (!write_cyc_q) begin
							rdata_q <= word ? FL_DQ_I : {8'h00, FL_DQ_I[7:0]};
						end
						cnt_q <= IDLE_CYC;
						st_q  <= (st_q == ST_SETUP && two_q) ? ST_GAP : ST_DONE;
					end
				end
				ST_GAP: begin
					// Strobes high for one cycle so the device latches the setup
					cnt_q <= STROBE_CYC;
					st_q  <= ST_CYC2;
				end
				ST_DONE: begin
					// Completion waits for the device to leave its busy state
					if (!FL_BUSY) begin
						done_q <= 1'b1;
						st_q   <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Program supply raised as the second cycle starts, held until completion
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hold_vpp_q <= 1'b0;
		end else if (st_q == ST_GAP) begin
			hold_vpp_q <= 1'b1;
		end else if (st_q == ST_DONE && !FL_BUSY) begin
			hold_vpp_q <= 1'b0;
		end
	end

	// Tracks that array reads are stale until read-array is sent
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			need_rdarray_q <= 1'b0;
		end else if (st_q == ST_DONE && !FL_BUSY && two_q) begin
			need_rdarray_q <= 1'b1;
		end else if (st_q == ST_DONE && cmd1_q == CMD_READ_ARRAY && write_cyc_q) begin
			need_rdarray_q <= 1'b0;
		end
	end

	// Pin drive; strobe low only in active cycles, rising edge latches
	always_comb begin
		logic active;
		active                    = (st_q == ST_SETUP) || (st_q == ST_CYC2);
		FL_PINS.ce_n              = ~active;
		FL_PINS.we_n              = ~(active & write_cyc_q);
		FL_PINS.oe_n              = ~(active & ~write_cyc_q);
		FL_PINS.word_mode         = word;
		FL_PINS.addr              = addr_q[18:1];
		FL_PINS.id_hv             = (op == OP_IDHV);
		if (op == OP_IDHV) begin
			FL_PINS.addr = {17'h00000, addr_q[1]};
		end
		FL_PINS.unlock_hv         = ctrl_q[CTRL_HV_BIT];
		FL_PINS.write_protect     = ctrl_q[CTRL_WPROT_BIT];
		FL_PINS.reset_powerdown_n = ~ctrl_q[CTRL_RST_BIT];
		FL_PINS.prog_supply_high  = hold_vpp_q | (st_q == ST_CYC2);
		// Data values outlive the strobe by a cycle so the rising edge latches them
		FL_DQ_O                   = (st_q == ST_CYC2 || (st_q == ST_DONE && two_q))
		                            ? data2_q : {8'h00, cmd1_q};
		if (!word) begin
			FL_DQ_O[15] = addr_q[0];
		end
		FL_DQ_OE                  = 16'h0000;
		if (active & write_cyc_q) begin
			// Upper lines only in word mode data cycles
			FL_DQ_OE = (word && st_q == ST_CYC2 && cmd1_q == CMD_PROG_SETUP)
			           ? 16'hFFFF : 16'h00FF;
		end
		if (active & ~word) begin
			FL_DQ_OE[15] = 1'b1;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	property p_no_we_oe;
		@(posedge CLK) disable iff (RST) !(!FL_PINS.we_n && !FL_PINS.oe_n);
	endproperty
	a_no_we_oe: assert property (p_no_we_oe) else $error("we and oe low together");

	property p_vpp_conf;
		@(posedge CLK) disable iff (RST) (st_q == ST_CYC2 || (st_q == ST_DONE && two_q))
			|-> FL_PINS.prog_supply_high;
	endproperty
	a_vpp_conf: assert property (p_vpp_conf) else $error("supply low in data cycle");

	property p_erase_pair;
		@(posedge CLK) disable iff (RST)
			(st_q == ST_GAP && cmd1_q == CMD_ERASE_SETUP) |=> (FL_DQ_O[7:0] == CMD_ERASE_CONF);
	endproperty
	a_erase_pair: assert property (p_erase_pair) else $error("confirm missing");

	property p_cmd_low;
		@(posedge CLK) disable iff (RST)
			(st_q == ST_SETUP && write_cyc_q) |-> (FL_DQ_OE[14:8] == 7'h00);
	endproperty
	a_cmd_low: assert property (p_cmd_low) else $error("command on upper lines");

	property p_byte_upper;
		@(posedge CLK) disable iff (RST) !word |-> (FL_DQ_OE[14:8] == 7'h00);
	endproperty
	a_byte_upper: assert property (p_byte_upper) else $error("upper lines in byte mode");

	property p_byte_a1;
		@(posedge CLK) disable iff (RST)
			(!word && !FL_PINS.ce_n) |-> (FL_DQ_OE[15] && FL_DQ_O[15] == addr_q[0]);
	endproperty
	a_byte_a1: assert property (p_byte_a1) else $error("low address bit not driven");

	property p_strobe_rise;
		@(posedge CLK) disable iff (RST) (st_q == ST_SETUP && two_q) |->
			##[1:8] (FL_PINS.we_n && FL_PINS.ce_n) ##1 !FL_PINS.we_n;
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("no gap between cycles");

	property p_idhv;
		@(posedge CLK) disable iff (RST) FL_PINS.id_hv |-> (FL_PINS.addr[17:1] == 17'h00000);
	endproperty
	a_idhv: assert property (p_idhv) else $error("upper address not low");
endmodule : bbfc_host
`default_nettype wire

// ==== hw/bbfc_pkg.sv ====
// Package: constants and types for the boot-block flash host controller
package bbfc_pkg;
	// Wishbone register offsets (byte addresses)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_WDATA  = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	// Control register fields
	localparam int CTRL_GO_BIT    = 0;
	localparam int CTRL_OP_LSB    = 1;
	localparam int CTRL_WORD_BIT  = 4;
	localparam int CTRL_HV_BIT    = 5;
	localparam int CTRL_WPROT_BIT = 6;
	localparam int CTRL_ID_BIT    = 7;
	localparam int CTRL_RST_BIT   = 8;
	// Status register fields
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	// Command codes sent on the low data lines
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
	localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_IDENTIFY    = 8'h90;
	// Operations requested by software
	localparam logic [2:0] OP_READ     = 3'h0;
	localparam logic [2:0] OP_PROGRAM  = 3'h1;
	localparam logic [2:0] OP_ERASE    = 3'h2;
	localparam logic [2:0] OP_RDARRAY  = 3'h3;
	localparam logic [2:0] OP_IDCMD    = 3'h4;
	localparam logic [2:0] OP_IDHV     = 3'h5;
	// Bus timing: strobe width and setup, in ns and cycles at 10 MHz
	localparam int CLK_NS       = 100;
	localparam int STROBE_NS    = 150;
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] IDLE_CYC   = 4'h1;
	// Flash pin bundle driven by the controller
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        word_mode;
		logic [17:0] addr;
		logic        id_hv;
		logic        unlock_hv;
		logic        reset_powerdown_n;
		logic        write_protect;
		logic        prog_supply_high;
	} bbfc_pins_t;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_CYC2, ST_GAP, ST_DONE} bbfc_state_t;
endpackage : bbfc_pkg

// ==== verif/bbfc_flash_model.sv ====
// Behavioural boot-block flash device facing the host controller
`timescale 1ns/1ns
`default_nettype none
module bbfc_flash_model
	import bbfc_pkg::*;
#(
	parameter logic [15:0] MFR_ID = 16'h1E5A, // Arbitrary value
	parameter logic [15:0] DEV_ID = 16'hC3A6  // Arbitrary value
)(
	input  wire bbfc_pins_t  pins,
	input  wire logic [15:0] h_o,
	input  wire logic [15:0] h_oe,
	output logic      [15:0] dq,
	output logic             busy
);
	logic [15:0] mem [16];
	logic [15:0] d_o;
	logic [1:0]  md   = 2'h0;
	logic [7:0]  pend = 8'h00;
	logic        flt  = 1'b0;
	int          errs = 0;
	wire logic   wm = pins.word_mode;
	wire logic [3:0] ix = pins.addr[3:0];
	wire logic   bt = pins.addr[17:3] == 15'h0;
	wire logic   ok = !bt || pins.unlock_hv || pins.write_protect;
	wire logic   hv = pins.id_hv && pins.addr[17:10] == 8'h0 && pins.addr[8:1] == 8'h0;
	wire logic   drv = pins.reset_powerdown_n && !pins.ce_n && !pins.oe_n;
	wire logic   wa = pins.reset_powerdown_n && !pins.ce_n && !pins.we_n;
	initial busy = 1'b0;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// Floating lines toggle so a stale level never passes for data
	always #50 flt = ~flt;
	////////////////////////////////////////////////////////////////////////////////
	// Capture at the end of the write pulse, whichever strobe rises first
	always @(negedge wa) begin
		if (!pins.oe_n)
			errs++;
		if (pend != 8'h00 && !pins.prog_supply_high)
			errs++;
		if (pend == CMD_ERASE_SETUP && h_o[7:0] == CMD_ERASE_CONF && ok) begin
			for (int i = 0; i < 8; i++)
				mem[{!bt, 3'(i)}] = 16'hFFFF;
		end else if ((pend == 8'h10 || pend == 8'h40) && ok) begin
			if (wm)
				mem[ix] = h_o;
			else if (h_o[15])
				mem[ix][15:8] = h_o[7:0];
			else
				mem[ix][7:0] = h_o[7:0];
		end
		if (pend != 8'h00) begin
			pend = 8'h00;
			md = 2'h1;
			busy = 1'b1;
			busy <= #400 1'b0;
		end else if (h_o[7:0] == CMD_READ_ARRAY)
			md = 2'h0;
		else if (h_o[7:0] == 8'h90)
			md = 2'h2;
		else if (h_o[7:0] inside {8'h10, 8'h20, 8'h40})
			pend = h_o[7:0];
	end
	// Reset pin low drops any pending command
	always @(negedge pins.reset_powerdown_n) begin
		md = 2'h0;
		pend = 8'h00;
	end
	// Read path: identifier, status or array
	always_comb begin
		d_o = (md == 2'h2 || hv) ? (pins.addr[0] ? DEV_ID : MFR_ID) : mem[ix];
		if (md == 2'h1 && !hv)
			d_o = 16'h0080;
		if (!wm && md == 2'h0 && !hv && h_o[15])
			d_o[7:0] = d_o[15:8];
	end
	for (genvar b = 0; b < 16; b++) begin : g_dq
		assign dq[b] = h_oe[b] ? h_o[b] : (drv && (wm || b < 8)) ? d_o[b] : flt ^ 1'(b % 2);
	end
endmodule : bbfc_flash_model
`default_nettype wire

// ==== verif/bbfc_host_tb_top.sv ====
// Self-checking bench for the boot-block flash host controller
`timescale 1ns/1ns
`default_nettype none
module bbfc_host_tb_top;
	import bbfc_pkg::*;
	localparam logic [31:0] W = 32'h10, WP = 32'h40, UL = 32'h20;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, q;
	int          mismatches = 0, n_compared = 0, cycles = 0;
	wire logic [31:0] dat_o;
	wire logic        ack, busy;
	wire logic [15:0] dq_i, dq_o, dq_oe;
	wire bbfc_pins_t  pins;
	bbfc_host dut_u (.CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wd), .WB_DAT_O(dat_o),
		.WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
		.FL_BUSY(busy), .FL_PINS(pins), .FL_DQ_I(dq_i), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe));
	bbfc_flash_model flash_u (.pins(pins), .h_o(dq_o), .h_oe(dq_oe), .dq(dq_i), .busy(busy));
	always #50 clk = ~clk;
	// Hang guard: a few thousand cycles cover the whole sequence
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Classic cycle; ack and read data taken at the rising edge, then released
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		do
			@(posedge clk);
		while (ack !== 1'b1);
		r = dat_o;
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	// One operation: address, data, go, poll until done
	task automatic run(input logic [31:0] a, d, input logic [2:0] op, input logic [31:0] cfg);
		wb(REG_ADDR, 1'b1, a, q);
		wb(REG_WDATA, 1'b1, d, q);
		wb(REG_CTRL, 1'b1, cfg | 32'({op, 1'b1}), q);
		for (int i = 0; i < 40; i++) begin
			wb(REG_STATUS, 1'b0, 32'h0, q);
			if (q[1:0] === 2'b10)
				break;
		end
		chk("status done", 32'h2, q & 32'h3);
		wb(REG_WDATA, 1'b0, 32'h0, q);
	endtask : run
	task automatic rdx(input logic [31:0] a, cfg, input logic [15:0] e, input string nm);
		run(a, 32'h0, OP_READ, cfg);
		chk(nm, cfg[4] ? {16'h0, e} : {24'h0, e[7:0]}, cfg[4] ? {16'h0, q[31:16]} : {24'h0, q[23:16]});
	endtask : rdx
	task automatic prog(input logic [31:0] a, d, cfg);
		run(a, d, OP_PROGRAM, cfg);
		wb(REG_STATUS, 1'b0, 32'h0, q);
		chk("stale array flag", 32'h4, q & 32'h4);
		run(a, 32'h0, OP_RDARRAY, cfg);
		wb(REG_STATUS, 1'b0, 32'h0, q);
		chk("stale array cleared", 32'h0, q & 32'h4);
	endtask : prog
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		wb(REG_CTRL, 1'b0, 32'h0, q);
		chk("ctrl reset bit", 32'h100, q & 32'h100);
		wb(4'h2, 1'b0, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		wb(REG_CTRL, 1'b1, 32'h0, q);
	endtask : t_reset
	task automatic t_data();
		prog(32'h50, 32'hA55A, W);
		rdx(32'h50, W, 16'hA55A, "word read");
		prog(32'h51, 32'h3C, 32'h0);
		rdx(32'h51, 32'h0, 16'h3C, "byte read");
		rdx(32'h50, W, 16'h3C5A, "word after byte");
		run(32'h50, 32'h0, OP_ERASE, W);
		run(32'h50, 32'h0, OP_RDARRAY, W);
		rdx(32'h50, W, 16'hFFFF, "erased word");
	endtask : t_data
	task automatic t_boot();
		prog(32'h04, 32'h1234, W);
		rdx(32'h04, W, 16'hFFFF, "boot locked");
		prog(32'h04, 32'h1234, W | WP);
		rdx(32'h04, W, 16'h1234, "boot write protect");
		prog(32'h06, 32'h5678, W | UL);
		rdx(32'h06, W, 16'h5678, "boot unlock");
	endtask : t_boot
	task automatic t_ident();
		run(32'h0, 32'h0, OP_IDCMD, W);
		rdx(32'h0, W, flash_u.MFR_ID, "maker code");
		rdx(32'h2, W, flash_u.DEV_ID, "device code");
		rdx(32'h2, 32'h0, flash_u.DEV_ID, "byte device code");
		run(32'h0, 32'h0, OP_RDARRAY, W);
		run(32'h2, 32'h0, OP_IDHV, W);
		chk("hv device code", {16'h0, flash_u.DEV_ID}, {16'h0, q[31:16]});
		run(32'h0, 32'h0, OP_IDHV, W);
		chk("hv maker code", {16'h0, flash_u.MFR_ID}, {16'h0, q[31:16]});
	endtask : t_ident
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_data();
		t_boot();
		t_ident();
		chk("flash side faults", 32'h0, 32'(flash_u.errs));
		results();
	end
endmodule : bbfc_host_tb_top
`default_nettype wire
